/* rhpm_params.svh */
`ifndef RHPM_PARAMS_SVH
`define RHPM_PARAMS_SVH

// ==========================================
// Register location and layout
`define RHPM_REG_OFFSET 12'h04c
`define RHPM_MASK_HI 31
`define RHPM_MASK_LO 16
`define RHPM_FLAG_HI 15
`define RHPM_FLAG_LO 0
`define RHPM_RESERVED_PORT 0
`define RHPM_FIRST_PORT 1
`define RHPM_FIELD_RESET 16'h0000
`define RHPM_WORD_RESET 32'h0000_0000
`define RHPM_MAX_PORTS 15
`define RHPM_FIELD_W 16

`endif

/* rhpm_pkg.sv */
package rhpm_pkg;

  // ==========================================
  // Block state
  typedef struct packed {
    logic [15:0] powerSelMask;
    logic [15:0] nonremFlags;
    logic [15:0] portPower;
    logic [31:0] rdData;
  } rhpm_state_t;

endpackage : rhpm_pkg

/* rhpm_root_hub_port_masks.sv */
// Operation
// RULE1: Register decoded at offset 4Ch from base
// RULE2: Software programs both fields at initialization
// RULE3: Power select mask held in bits 31-16
// RULE4: Masked port follows only per-port commands
// RULE5: Unmasked port follows global set/clear
// RULE6: Ganged mode ignores mask, all ports global
// RULE7: Mask bit 0 reserved, bit n port n
// RULE8: Bits 15-0 flag non-removable devices
// RULE9: Flag bit 0 reserved, bit n port n
// RULE10: Global set powers only unmasked ports
// RULE11: Global clear unpowers only unmasked ports
// RULE12: Unimplemented port bits ignore writes, read zero
`timescale 1ns/1ps
`default_nettype none
`include "rhpm_params.svh"

module rhpm_root_hub_port_masks
  import rhpm_pkg::*;
#(
  parameter int NUM_PORTS = `RHPM_MAX_PORTS,
  parameter int ADDR_W = 12
) (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] regAddr,
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [31:0] regWrData,
  output logic [31:0] regRdData,
  output logic regHit,
  input wire logic perPortSwitchingSelect,
  input wire logic setAllPowerCmd,
  input wire logic clearAllPowerCmd,
  input wire logic [15:0] setPortPowerCmd,
  input wire logic [15:0] clearPortPowerCmd,
  output logic [15:0] portPowerOn,
  output logic [15:0] portPowerSelectMask,
  output logic [15:0] nonremovableFlags
);

  // ==========================================
  // Helpers
  function automatic logic [15:0] implPorts(input int n);
    logic [15:0] m;
    m = `RHPM_FIELD_RESET;
    for (int i = `RHPM_FIRST_PORT; i < `RHPM_FIELD_W; i++) begin
      if (i <= n) begin
        m[i] = 1'b1;
      end
    end
    return m;
  endfunction : implPorts

  function automatic logic isRegAddr(input logic [ADDR_W-1:0] a);
    return a == ADDR_W'(`RHPM_REG_OFFSET);
  endfunction : isRegAddr

  function automatic logic [15:0] applyCmd(input logic [15:0] pwr, input logic [15:0] own,
    input logic [15:0] setBits, input logic [15:0] clrBits);
    logic [15:0] p;
    p = pwr | (setBits & own);
    p = p & ~(clrBits & own);
    return p;
  endfunction : applyCmd

  localparam logic [15:0] IMPL = implPorts(NUM_PORTS);

  // ==========================================
  // State
  rhpm_state_t stateQ;
  rhpm_state_t stateD;
  logic [15:0] globalOwned;
  logic [15:0] localOwned;

  // ==========================================
  // Decode and next state
  assign regHit = isRegAddr(regAddr); // see RULE1

  always_comb begin
    stateD = stateQ;
    // Ganged mode: every port takes global commands
    globalOwned = perPortSwitchingSelect ? (IMPL & ~stateQ.powerSelMask) : IMPL; // see RULE6
    localOwned =
      perPortSwitchingSelect ? (IMPL & stateQ.powerSelMask) : `RHPM_FIELD_RESET; // see RULE4
    if (regWrEn && regHit) begin // see RULE1
      stateD.powerSelMask =
        regWrData[`RHPM_MASK_HI:`RHPM_MASK_LO] & IMPL; // see RULE3, RULE7, RULE12
      stateD.nonremFlags =
        regWrData[`RHPM_FLAG_HI:`RHPM_FLAG_LO] & IMPL; // see RULE8, RULE9, RULE12
    end
    // Global commands first, then per-port; clear wins in each
    stateD.portPower = applyCmd(stateQ.portPower, globalOwned,
      {`RHPM_FIELD_W{setAllPowerCmd}},
      {`RHPM_FIELD_W{clearAllPowerCmd}}); // see RULE5, RULE10, RULE11
    stateD.portPower = applyCmd(stateD.portPower, localOwned,
      setPortPowerCmd, clearPortPowerCmd); // see RULE4
    if (regRdEn && regHit) begin
      stateD.rdData = {stateQ.powerSelMask, stateQ.nonremFlags};
    end else if (regRdEn) begin
      stateD.rdData = `RHPM_WORD_RESET;
    end
  end

  // ==========================================
  // State register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      stateQ <= '0;
    end else begin
      stateQ <= stateD;
    end
  end

  // ==========================================
  // Outputs
  assign regRdData = stateQ.rdData;
  assign portPowerOn = stateQ.portPower;
  assign portPowerSelectMask = stateQ.powerSelMask;
  assign nonremovableFlags = stateQ.nonremFlags;

  // ==========================================
  // Checks
  decode_miss_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE1
    (regWrEn && !isRegAddr(regAddr)) |=>
      (portPowerSelectMask == $past(portPowerSelectMask)
       && nonremovableFlags == $past(nonremovableFlags)))
    else $error("Write off the register offset changed it");

  mask_store_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE3
    (regWrEn && regHit)
      |=> portPowerSelectMask == ($past(regWrData[`RHPM_MASK_HI:`RHPM_MASK_LO]) & IMPL))
    else $error("Power select mask not stored from upper half");

  flag_store_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE8
    (regWrEn && regHit)
      |=> nonremovableFlags == ($past(regWrData[`RHPM_FLAG_HI:`RHPM_FLAG_LO]) & IMPL))
    else $error("Removability flags not stored from lower half");

  reserved_bits_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE7, RULE9
    !portPowerSelectMask[`RHPM_RESERVED_PORT] && !nonremovableFlags[`RHPM_RESERVED_PORT])
    else $error("Reserved port bit is set");

  unimpl_zero_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE12
    ((portPowerSelectMask | nonremovableFlags | portPowerOn) & ~IMPL) == 16'h0000)
    else $error("Unimplemented port bit is set");

  masked_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE4
    (perPortSwitchingSelect && (setAllPowerCmd || clearAllPowerCmd)
     && setPortPowerCmd == 16'h0000 && clearPortPowerCmd == 16'h0000)
      |=> (portPowerOn & $past(portPowerSelectMask))
          == ($past(portPowerOn) & $past(portPowerSelectMask)))
    else $error("Masked port followed a global command");

  global_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE10
    (perPortSwitchingSelect && setAllPowerCmd && !clearAllPowerCmd)
      |=> (portPowerOn & ~$past(portPowerSelectMask) & IMPL)
          == (IMPL & ~$past(portPowerSelectMask)))
    else $error("Global set missed an unmasked port");

  global_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE11
    (perPortSwitchingSelect && clearAllPowerCmd)
      |=> (portPowerOn & ~$past(portPowerSelectMask)) == 16'h0000)
    else $error("Global clear missed an unmasked port");

  ganged_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE6, RULE5
    (!perPortSwitchingSelect && setAllPowerCmd && !clearAllPowerCmd) |=> portPowerOn == IMPL)
    else $error("Ganged set did not power every port");

  read_back_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE1
    (regRdEn && regHit) |=> regRdData == {$past(portPowerSelectMask), $past(nonremovableFlags)})
    else $error("Read data does not match register");

  read_miss_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE1
    (regRdEn && !regHit) |=> regRdData == `RHPM_WORD_RESET)
    else $error("Read off the register offset returned data");

  read_stand_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE1
    !regRdEn |=> regRdData == $past(regRdData))
    else $error("Read data changed without a read");

  read_old_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE1
    (regRdEn && regWrEn && regHit) |=> regRdData == {$past(portPowerSelectMask), $past(nonremovableFlags)})
    else $error("Read during write did not return the old value");

  mask_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE3
    !(regWrEn && regHit) |=> portPowerSelectMask == $past(portPowerSelectMask))
    else $error("Power select mask changed without a write");

  flag_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE8
    !(regWrEn && regHit) |=> nonremovableFlags == $past(nonremovableFlags))
    else $error("Removability flags changed without a write");

  port_set_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE4
    perPortSwitchingSelect
      |=> (portPowerOn & $past(portPowerSelectMask) & $past(setPortPowerCmd)
           & ~$past(clearPortPowerCmd))
          == ($past(portPowerSelectMask) & $past(setPortPowerCmd) & ~$past(clearPortPowerCmd)))
    else $error("Per-port set missed a masked port");

  port_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE4
    perPortSwitchingSelect
      |=> (portPowerOn & $past(portPowerSelectMask) & $past(clearPortPowerCmd))
          == `RHPM_FIELD_RESET)
    else $error("Per-port clear missed a masked port");

  unmasked_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE5
    (perPortSwitchingSelect && !setAllPowerCmd && !clearAllPowerCmd)
      |=> (portPowerOn & ~$past(portPowerSelectMask))
          == ($past(portPowerOn) & ~$past(portPowerSelectMask)))
    else $error("Unmasked port followed a per-port command");

  ganged_clear_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE6
    (!perPortSwitchingSelect && clearAllPowerCmd) |=> portPowerOn == `RHPM_FIELD_RESET)
    else $error("Ganged clear left a port powered");

  ganged_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE6
    (!perPortSwitchingSelect && !setAllPowerCmd && !clearAllPowerCmd)
      |=> portPowerOn == $past(portPowerOn))
    else $error("Ganged port followed a per-port command");

  reserved_power_a: assert property (@(posedge sys_clk) disable iff (!rst_b) // see RULE7
    !portPowerOn[`RHPM_RESERVED_PORT])
    else $error("Reserved port is powered");

endmodule : rhpm_root_hub_port_masks
`default_nettype wire

/* rhpm_root_hub_port_masks_test.sv */
`timescale 1ns/1ps
`default_nettype none
module rhpm_root_hub_port_masks_test;
  logic sys_clk = 0, rst_b = 0, regWrEn = 0, regRdEn = 0, sel = 0, setAll = 0, clrAll = 0;
  logic regHit;
  logic [11:0] regAddr = 12'h000;
  logic [31:0] regWrData = 32'h0000_0000, regRdData;
  logic [15:0] setPort = 16'h0000, clrPort = 16'h0000, pwr, mask, flags;
  int nFail = 0, checksDone = 0;
  always #20 sys_clk = ~sys_clk;
  rhpm_root_hub_port_masks #(.NUM_PORTS(4), .ADDR_W(12)) uut (.sys_clk(sys_clk), .rst_b(rst_b),
    .regAddr(regAddr), .regWrEn(regWrEn), .regRdEn(regRdEn), .regWrData(regWrData),
    .regRdData(regRdData), .regHit(regHit), .perPortSwitchingSelect(sel),
    .setAllPowerCmd(setAll), .clearAllPowerCmd(clrAll), .setPortPowerCmd(setPort),
    .clearPortPowerCmd(clrPort), .portPowerOn(pwr), .portPowerSelectMask(mask),
    .nonremovableFlags(flags));
  // ==========================================
  // Helpers
  task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      nFail++;
      $display("mismatch %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge sys_clk);
    regAddr <= a; regWrData <= d; regWrEn <= 1'b1;
    @(posedge sys_clk);
    regWrEn <= 1'b0;
  endtask : wr
  task rd(input logic [11:0] a, input logic [31:0] exp);
    @(posedge sys_clk);
    regAddr <= a; regRdEn <= 1'b1;
    @(posedge sys_clk);
    regRdEn <= 1'b0;
    @(negedge sys_clk);
    chk("read", regRdData, exp);
  endtask : rd
  task cmd(input logic s, input logic c, input logic [15:0] sp, input logic [15:0] cp,
           input logic [15:0] exp);
    @(posedge sys_clk);
    setAll <= s; clrAll <= c; setPort <= sp; clrPort <= cp;
    @(posedge sys_clk);
    setAll <= 1'b0; clrAll <= 1'b0; setPort <= 16'h0000; clrPort <= 16'h0000;
    @(negedge sys_clk);
    chk("power", {16'h0000, pwr}, {16'h0000, exp});
  endtask : cmd
  // ==========================================
  // Scenarios
  task t_regs;
    rd(12'h04C, 32'h0000_0000);
    wr(12'h04C, 32'hFFFF_FFFF);
    @(negedge sys_clk);
    chk("fields", {mask, flags}, 32'h001E_001E);
    rd(12'h04C, 32'h001E_001E);
    chk("hit", {31'h0000_0000, regHit}, 32'h0000_0001);
    wr(12'h050, 32'h0000_0000);
    rd(12'h050, 32'h0000_0000);
    chk("miss", {31'h0000_0000, regHit}, 32'h0000_0000);
    rd(12'h04C, 32'h001E_001E);
    wr(12'h04C, 32'h0004_0012);
    rd(12'h04C, 32'h0004_0012);
  endtask : t_regs
  task t_ganged;
    cmd(1'b1, 1'b0, 16'h0000, 16'h0000, 16'h001E);
    cmd(1'b0, 1'b0, 16'h0000, 16'h001E, 16'h001E);
    cmd(1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0000);
  endtask : t_ganged
  task t_perport;
    @(posedge sys_clk);
    sel <= 1'b1;
    cmd(1'b1, 1'b0, 16'h0000, 16'h0000, 16'h001A);
    cmd(1'b0, 1'b0, 16'h0004, 16'h0000, 16'h001E);
    cmd(1'b0, 1'b1, 16'h0000, 16'h0000, 16'h0004);
    cmd(1'b0, 1'b0, 16'h0002, 16'h0000, 16'h0004);
    cmd(1'b0, 1'b0, 16'h0000, 16'h0004, 16'h0000);
  endtask : t_perport
  task summarize;
    if (nFail == 0 && checksDone > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : summarize
  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(negedge sys_clk);
    chk("reset", {mask, flags}, 32'h0000_0000);
    t_regs;
    t_ganged;
    t_perport;
    summarize;
  end
  initial begin
    repeat (2000) @(posedge sys_clk);
    nFail++;
    summarize;
  end
endmodule : rhpm_root_hub_port_masks_test
`default_nettype wire
